// ### core/pfc_defs.vh
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
// register indices; byte address is four times the index
`define PFC_IDX_HOLDOFF_TIME_Q 12'h608
`define PFC_IDX_PAUSE_TIME_Q 12'h609
`define PFC_IDX_QUEUE_SELECT 12'h60A
`define PFC_IDX_UNI_EN 12'h60B
`define PFC_IDX_UNI_TIME 12'h60C
`define PFC_IDX_DA_LOW 12'h60D
`define PFC_IDX_DA_HIGH 12'h60E
`define PFC_IDX_SA_LOW 12'h60F
`define PFC_IDX_SA_HIGH 12'h610
`define PFC_IDX_CTRL 12'h611
`define PFC_IDX_STATUS 12'h612
// reset values
`define PFC_RST_UNI_EN 1'h0
`define PFC_RST_UNI_TIME 16'hFFFF
`define PFC_RST_DA_LOW 32'hC2000001
`define PFC_RST_DA_HIGH 16'h0180
`define PFC_RST_SA_LOW 32'hCBFC5ADD
`define PFC_RST_SA_HIGH 16'hE100
`define PFC_RST_Q_HOLDOFF 16'hFFFF
`define PFC_RST_Q_PAUSE 16'hFFFF
// pause quantum timing
`define PFC_QUANTUM_BITS 512
`define PFC_DATAPATH_BITS 512
`define PFC_CYC_PER_QUANTUM (`PFC_QUANTUM_BITS / `PFC_DATAPATH_BITS)
// axi responses
`define PFC_RESP_OKAY 2'h0
`define PFC_RESP_SLVERR 2'h2
`endif

// ### core/pfc_queue_table.v
`timescale 1ns/1ns
`default_nettype none
// small per-queue table, registered read data
module pfc_queue_table #(
   parameter DEPTH_LOG2 = 3,
   parameter WIDTH = 16,
   parameter [15:0] INIT = 16'hFFFF
) (
   input wire aclk,
   input wire aresetn,
   input wire wr_en,
   input wire [DEPTH_LOG2-1:0] wr_index,
   input wire [WIDTH-1:0] wr_data,
   input wire [DEPTH_LOG2-1:0] rd_index,
   output reg [WIDTH-1:0] rd_data,
   output wire [(WIDTH<<DEPTH_LOG2)-1:0] all_data
);
   reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];
   integer i;
   genvar g;
   generate
      for (g = 0; g < (1<<DEPTH_LOG2); g = g + 1) begin : flat
         assign all_data[g*WIDTH +: WIDTH] = mem[g];
      end
   endgenerate
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (i = 0; i < (1<<DEPTH_LOG2); i = i + 1) begin
            mem[i] <= INIT[WIDTH-1:0];
         end
         rd_data <= INIT[WIDTH-1:0];
      end else begin
         if (wr_en) begin
            mem[wr_index] <= wr_data;
         end
         rd_data <= mem[rd_index];
      end
   end
endmodule // pfc_queue_table
`default_nettype wire

// ### core/pfc_holdoff_timer.v
`timescale 1ns/1ns
`default_nettype none
// one queue's hold-off counter, loaded at the xoff send
module pfc_holdoff_timer #(
   parameter CYC_PER_QUANTUM = 1
) (
   input wire aclk,
   input wire aresetn,
   input wire xoff_sent,
   input wire pause_req,
   input wire uni_en,
   input wire [15:0] uni_time,
   input wire q_en,
   input wire [15:0] q_time,
   output wire holdoff_active
);
   localparam PW = (CYC_PER_QUANTUM > 1) ? $clog2(CYC_PER_QUANTUM) : 1;
   reg [15:0] quanta_left;
   reg [PW-1:0] prescale;
   reg [15:0] load_value;
   wire quantum_tick;
   always @* begin
      load_value = 16'h0000;
      if (q_en && q_time > load_value) begin
         load_value = q_time;
      end
      if (uni_en && uni_time > load_value) begin
         load_value = uni_time;
      end
   end
   // quantum is one cycle when the datapath carries 512 bits per clock
   assign quantum_tick = (CYC_PER_QUANTUM <= 1) ? 1'b1 :
      (prescale == CYC_PER_QUANTUM[PW-1:0] - 1'b1);
   assign holdoff_active = (quanta_left != 16'h0000);
   always @(posedge aclk) begin
      if (!aresetn) begin
         quanta_left <= 16'h0000;
         prescale <= {PW{1'b0}};
      end else if (xoff_sent) begin
         quanta_left <= load_value;
         prescale <= {PW{1'b0}};
      end else if (!pause_req && !uni_en) begin
         // per-queue hold-off lapses once the pause request is dropped while uniform hold-off is off
         quanta_left <= 16'h0000;
      end else if (holdoff_active) begin
         prescale <= quantum_tick ? {PW{1'b0}} : prescale + 1'b1;
         if (quantum_tick) begin
            quanta_left <= quanta_left - 16'h0001;
         end
      end
   end
endmodule // pfc_holdoff_timer
`default_nettype wire

// ### core/pfc_tx_pause_config.v
// The AXI4-Lite slave port was chosen for this implementation.
`include "pfc_defs.vh"
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Overview of operation
// - With the uniform enable set, every queue holds off retransmission after its xoff.
// - Each queue's hold-off is the larger of its own time and the uniform time, each counted only when enabled.
// - The uniform time is 16 bits of pause quanta, a quantum being 512 bit times.
// - On the 100G datapath one quantum counts as one clock cycle.
// - Uniform hold-off and frame address registers exist only in priority flow mode.
// - Frame destination is the high destination word above the low word.
// - Destination resets to the standard multicast address and is software writable.
// - Any destination value is placed in frames unchanged.
// - Source low 32 bits come from the low source register; the high 16 bits reset to E100.
// - Per-queue hold-off needs its enable and the queue's pause request at the xoff; dropping the request ends it only while uniform hold-off is off.
// - Per-queue hold-off and pause time table accesses use a 3-bit queue select.
// -----------------------------------------------------------------------------
module pfc_tx_pause_config #(
   parameter PRIORITY_MODE = 1,
   parameter NUM_QUEUES_LOG2 = 3,
   parameter CYC_PER_QUANTUM = `PFC_CYC_PER_QUANTUM
) (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [(1<<NUM_QUEUES_LOG2)-1:0] xoff_sent,
   input wire [(1<<NUM_QUEUES_LOG2)-1:0] pause_req,
   output reg [(1<<NUM_QUEUES_LOG2)-1:0] holdoff_active,
   output reg [47:0] pfc_dest_addr,
   output reg [47:0] pfc_src_addr,
   output wire [(16<<NUM_QUEUES_LOG2)-1:0] pause_time_table
);
   localparam NQ = 1 << NUM_QUEUES_LOG2;
   // -----------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------
   reg uniform_holdoff_enable;
   reg [15:0] uniform_holdoff_time;
   reg [31:0] pfc_dest_addr_low;
   reg [15:0] pfc_dest_addr_high;
   reg [31:0] pfc_src_addr_low;
   reg [15:0] pfc_src_addr_high;
   reg [NUM_QUEUES_LOG2-1:0] queue_select_index;
   // per-queue hold-off enables, one bit per queue
   reg [NQ-1:0] per_queue_holdoff_en;
   // -----------------------------------------------------------------------
   // axi4-lite write path
   // -----------------------------------------------------------------------
   reg [31:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   wire do_write;
   wire [11:0] w_idx;
   wire [31:0] wr_mask;
   wire [31:0] wmerge_base;
   reg [31:0] wr_cur;
   reg w_ok;
   // a channel closes while its beat waits or a response is out: one write at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign w_idx = aw_addr[13:2];
   assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   // strobes merge with the current value so narrow writes keep other bytes
   assign wmerge_base = (w_data & wr_mask) | (wr_cur & ~wr_mask);
   wire hq_wr = do_write && w_ok && (w_idx == `PFC_IDX_HOLDOFF_TIME_Q);
   wire pq_wr = do_write && w_ok && (w_idx == `PFC_IDX_PAUSE_TIME_Q);
   wire [15:0] hq_rd;
   wire [15:0] pq_rd;
   wire [(16<<NUM_QUEUES_LOG2)-1:0] hq_all;
   // -----------------------------------------------------------------------
   // write decode
   // -----------------------------------------------------------------------
   // decode of what a write index maps to, and the current value for merging
   always @* begin
      w_ok = 1'b1;
      wr_cur = 32'h00000000;
      case (w_idx)
         `PFC_IDX_HOLDOFF_TIME_Q: wr_cur = {16'h0000, hq_rd};
         `PFC_IDX_PAUSE_TIME_Q: wr_cur = {16'h0000, pq_rd};
         `PFC_IDX_QUEUE_SELECT: wr_cur[NUM_QUEUES_LOG2-1:0] = queue_select_index;
         `PFC_IDX_CTRL: wr_cur[NQ-1:0] = per_queue_holdoff_en;
         `PFC_IDX_UNI_EN: begin
            w_ok = (PRIORITY_MODE != 0);
            wr_cur = {31'h00000000, uniform_holdoff_enable};
         end
         `PFC_IDX_UNI_TIME: begin
            w_ok = (PRIORITY_MODE != 0);
            wr_cur = {16'h0000, uniform_holdoff_time};
         end
         `PFC_IDX_DA_LOW: begin
            w_ok = (PRIORITY_MODE != 0);
            wr_cur = pfc_dest_addr_low;
         end
         `PFC_IDX_DA_HIGH: begin
            w_ok = (PRIORITY_MODE != 0);
            wr_cur = {16'h0000, pfc_dest_addr_high};
         end
         `PFC_IDX_SA_LOW: begin
            w_ok = (PRIORITY_MODE != 0);
            wr_cur = pfc_src_addr_low;
         end
         `PFC_IDX_SA_HIGH: begin
            w_ok = (PRIORITY_MODE != 0);
            wr_cur = {16'h0000, pfc_src_addr_high};
         end
         default: w_ok = 1'b0;
      endcase
      // addresses above the window are refused, never aliased onto a register
      if (aw_addr[31:14] != 18'h00000) begin
         w_ok = 1'b0;
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h00000000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PFC_RESP_OKAY;
         uniform_holdoff_enable <= `PFC_RST_UNI_EN;
         uniform_holdoff_time <= `PFC_RST_UNI_TIME;
         pfc_dest_addr_low <= `PFC_RST_DA_LOW;
         pfc_dest_addr_high <= `PFC_RST_DA_HIGH;
         pfc_src_addr_low <= `PFC_RST_SA_LOW;
         pfc_src_addr_high <= `PFC_RST_SA_HIGH;
         queue_select_index <= {NUM_QUEUES_LOG2{1'b0}};
         per_queue_holdoff_en <= {NQ{1'b0}};
      end else begin
         // address and data come in either order; the first waits for the other
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_ok ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
            if (w_ok) begin
               case (w_idx)
                  `PFC_IDX_QUEUE_SELECT: queue_select_index <= wmerge_base[NUM_QUEUES_LOG2-1:0];
                  `PFC_IDX_CTRL: per_queue_holdoff_en <= wmerge_base[NQ-1:0];
                  `PFC_IDX_UNI_EN: uniform_holdoff_enable <= wmerge_base[0];
                  `PFC_IDX_UNI_TIME: uniform_holdoff_time <= wmerge_base[15:0];
                  `PFC_IDX_DA_LOW: pfc_dest_addr_low <= wmerge_base;
                  `PFC_IDX_DA_HIGH: pfc_dest_addr_high <= wmerge_base[15:0];
                  `PFC_IDX_SA_LOW: pfc_src_addr_low <= wmerge_base;
                  `PFC_IDX_SA_HIGH: pfc_src_addr_high <= wmerge_base[15:0];
                  default: ;
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // -----------------------------------------------------------------------
   // per-queue tables, both indexed by the queue select
   // -----------------------------------------------------------------------
   pfc_queue_table #(
      .DEPTH_LOG2(NUM_QUEUES_LOG2),
      .WIDTH(16),
      .INIT(`PFC_RST_Q_HOLDOFF)
   ) u_holdoff_table (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(hq_wr),
      .wr_index(queue_select_index),
      .wr_data(wmerge_base[15:0]),
      .rd_index(queue_select_index),
      .rd_data(hq_rd),
      .all_data(hq_all)
   );
   pfc_queue_table #(
      .DEPTH_LOG2(NUM_QUEUES_LOG2),
      .WIDTH(16),
      .INIT(`PFC_RST_Q_PAUSE)
   ) u_pause_table (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(pq_wr),
      .wr_index(queue_select_index),
      .wr_data(wmerge_base[15:0]),
      .rd_index(queue_select_index),
      .rd_data(pq_rd),
      .all_data(pause_time_table)
   );
   // -----------------------------------------------------------------------
   // axi4-lite read path
   // -----------------------------------------------------------------------
   // one-cycle wait state lets the table's registered read data settle
   reg rd_wait;
   reg [11:0] r_idx;
   reg r_bad;
   wire [NQ-1:0] holdoff_raw;
   assign s_axi_arready = !rd_wait && !s_axi_rvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_wait <= 1'b0;
         r_idx <= 12'h000;
         r_bad <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PFC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rd_wait <= 1'b1;
         r_idx <= s_axi_araddr[13:2];
         r_bad <= (s_axi_araddr[31:14] != 18'h00000);
      end else if (rd_wait) begin
         rd_wait <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `PFC_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         case (r_idx)
            `PFC_IDX_HOLDOFF_TIME_Q: s_axi_rdata <= {16'h0000, hq_rd};
            `PFC_IDX_PAUSE_TIME_Q: s_axi_rdata <= {16'h0000, pq_rd};
            `PFC_IDX_QUEUE_SELECT: s_axi_rdata[NUM_QUEUES_LOG2-1:0] <= queue_select_index;
            `PFC_IDX_CTRL: s_axi_rdata[NQ-1:0] <= per_queue_holdoff_en;
            `PFC_IDX_STATUS: s_axi_rdata[NQ-1:0] <= holdoff_raw;
            `PFC_IDX_UNI_EN: s_axi_rdata[0] <= uniform_holdoff_enable;
            `PFC_IDX_UNI_TIME: s_axi_rdata[15:0] <= uniform_holdoff_time;
            `PFC_IDX_DA_LOW: s_axi_rdata <= pfc_dest_addr_low;
            `PFC_IDX_DA_HIGH: s_axi_rdata[15:0] <= pfc_dest_addr_high;
            `PFC_IDX_SA_LOW: s_axi_rdata <= pfc_src_addr_low;
            `PFC_IDX_SA_HIGH: s_axi_rdata[15:0] <= pfc_src_addr_high;
            default: s_axi_rresp <= `PFC_RESP_SLVERR;
         endcase
         // in standard flow mode the priority-only registers read as absent
         if (r_bad || (PRIORITY_MODE == 0 && r_idx >= `PFC_IDX_UNI_EN
               && r_idx <= `PFC_IDX_SA_HIGH)) begin
            s_axi_rresp <= `PFC_RESP_SLVERR;
            s_axi_rdata <= 32'h00000000;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // -----------------------------------------------------------------------
   // per-queue hold-off timers and frame addresses
   // -----------------------------------------------------------------------
   // each queue times its own hold-off; only the uniform settings are shared
   genvar q;
   generate
      for (q = 0; q < NQ; q = q + 1) begin : queue
         pfc_holdoff_timer #(
            .CYC_PER_QUANTUM(CYC_PER_QUANTUM)
         ) u_timer (
            .aclk(aclk),
            .aresetn(aresetn),
            .xoff_sent(xoff_sent[q]),
            .pause_req(pause_req[q]),
            .uni_en(uniform_holdoff_enable && (PRIORITY_MODE != 0)),
            .uni_time(uniform_holdoff_time),
            .q_en(per_queue_holdoff_en[q] && pause_req[q]),
            .q_time(hq_all[q*16 +: 16]),
            .holdoff_active(holdoff_raw[q])
         );
      end
   endgenerate
   // registered copies give the frame builder outputs that start on a flop
   always @(posedge aclk) begin
      if (!aresetn) begin
         holdoff_active <= {NQ{1'b0}};
         pfc_dest_addr <= {`PFC_RST_DA_HIGH, `PFC_RST_DA_LOW};
         pfc_src_addr <= {`PFC_RST_SA_HIGH, `PFC_RST_SA_LOW};
      end else begin
         holdoff_active <= holdoff_raw;
         pfc_dest_addr <= {pfc_dest_addr_high, pfc_dest_addr_low};
         pfc_src_addr <= {pfc_src_addr_high, pfc_src_addr_low};
      end
   end
endmodule // pfc_tx_pause_config
`default_nettype wire

// ### sim/pfc_tx_pause_config_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pfc_tx_pause_config_props #(
   parameter NUM_QUEUES_LOG2 = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [(1<<NUM_QUEUES_LOG2)-1:0] xoff_sent,
   input wire logic [(1<<NUM_QUEUES_LOG2)-1:0] holdoff_active,
   input wire logic [47:0] pfc_dest_addr,
   input wire logic [47:0] pfc_src_addr
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------
   // register bus
   // ------------------------------
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // read data waits one idle cycle, with the address channel closed
   sequence s_rd_answer;
      !s_axi_rvalid && !s_axi_arready ##1 s_axi_rvalid;
   endsequence
   a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
      else $error("write response late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (s_rd_take |=> s_rd_answer)
      else $error("read data timing wrong");
   a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read returned data");
   // ------------------------------
   // frame addresses and hold-off
   // ------------------------------
   a_reset_addr: assert property (
      $rose(aresetn) |-> pfc_dest_addr == 48'h0180C2000001 && pfc_src_addr == 48'hE100CBFC5ADD)
      else $error("frame address reset value wrong");
   a_addr_written: assert property (
      !$stable(pfc_dest_addr) || !$stable(pfc_src_addr) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("frame address moved without a write");
   a_holdoff_cause: assert property (
      (holdoff_active & ~$past(holdoff_active) & ~$past(xoff_sent, 2)) == '0)
      else $error("hold-off started without xoff two cycles before");
endmodule // pfc_tx_pause_config_props
bind pfc_tx_pause_config pfc_tx_pause_config_props #(
   .NUM_QUEUES_LOG2(NUM_QUEUES_LOG2)
) i_pfc_tx_pause_config_props (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xoff_sent, .holdoff_active,
   .pfc_dest_addr, .pfc_src_addr
);
`default_nettype wire

// ### sim/pfc_link_partner.sv
`timescale 1ns/1ns
`default_nettype none
// link partner: raises pause requests and receives the xoff frames
module pfc_link_partner #(
   parameter NQ = 8
) (
   input wire logic aclk,
   input wire logic [47:0] pfc_dest_addr,
   input wire logic [47:0] pfc_src_addr,
   output var logic [NQ-1:0] xoff_sent,
   output var logic [NQ-1:0] pause_req,
   output var logic [47:0] frame_da,
   output var logic [47:0] frame_sa
);
   initial begin
      xoff_sent = '0;
      pause_req = '0;
      frame_da = '0;
      frame_sa = '0;
   end
   // caller sits just past a rising edge; frame fields are taken with the pulse
   task automatic send_xoff(input int q);
      xoff_sent[q] <= 1'b1;
      frame_da <= pfc_dest_addr;
      frame_sa <= pfc_src_addr;
      @(posedge aclk);
      xoff_sent[q] <= 1'b0;
   endtask
   task automatic set_req(input logic [NQ-1:0] m);
      pause_req <= m;
   endtask
endmodule // pfc_link_partner
`default_nettype wire

// ### sim/pfc_tx_pause_config_test.sv
`include "pfc_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module pfc_tx_pause_config_test;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic s_axi_bready = 1, s_axi_rready = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] xoff_sent, pause_req, holdoff_active;
   logic [47:0] pfc_dest_addr, pfc_src_addr, frame_da, frame_sa;
   logic [127:0] pause_time_table;
   int err_total = 0, num_checks = 0;
   always #5 aclk = ~aclk;
   pfc_tx_pause_config i_pfc_tx_pause_config (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xoff_sent, .pause_req,
      .holdoff_active, .pfc_dest_addr, .pfc_src_addr, .pause_time_table
   );
   pfc_link_partner i_pfc_link_partner (
      .aclk, .pfc_dest_addr, .pfc_src_addr, .xoff_sent, .pause_req, .frame_da, .frame_sa
   );
   // ------------------------------
   // checks and bus cycles
   // ------------------------------
   task automatic chk_val(input string nm, input logic [47:0] e, input logic [47:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      chk_val(nm, {46'h0, e}, {46'h0, g});
   endtask
   // handshakes are sampled on the falling edge, which equals the rising-edge value
   task automatic axi_wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      s_axi_awaddr <= {18'h0, idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      b = 1'b0;
      for (int n = 0; n < 40 && !b; n++) begin
         @(negedge aclk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         if (b) r = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      chk_resp($sformatf("bresp %h", idx), er, r);
   endtask
   task automatic axi_rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a, v;
      s_axi_araddr <= {18'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      v = 1'b0;
      d = 'x;
      r = 'x;
      for (int n = 0; n < 40 && !v; n++) begin
         @(negedge aclk);
         a = s_axi_arvalid && s_axi_arready;
         v = s_axi_rvalid;
         if (v) d = s_axi_rdata;
         if (v) r = s_axi_rresp;
         @(posedge aclk);
         if (a) s_axi_arvalid <= 1'b0;
      end
   endtask
   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(idx, d, r);
      chk_resp($sformatf("rresp %h", idx), 2'h0, r);
      chk_val($sformatf("reg %h", idx), {16'h0, e}, {16'h0, d});
   endtask
   // counts hold-off cycles of queue q; every other queue must stay idle
   task automatic holdoff_run(input int q, input logic [7:0] req, input int e);
      logic [47:0] n;
      logic [7:0] other;
      n = '0;
      other = '0;
      i_pfc_link_partner.set_req(req);
      @(posedge aclk);
      i_pfc_link_partner.send_xoff(q);
      repeat (40) begin
         @(negedge aclk);
         n = n + holdoff_active[q];
         other = other | (holdoff_active & ~(8'h01 << q));
         @(posedge aclk);
      end
      chk_val($sformatf("holdoff q%0d", q), 48'(e), n);
      chk_val("holdoff other queues", 48'h0, {40'h0, other});
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_reset_values;
      rd_chk(`PFC_IDX_UNI_EN, 32'h0);
      rd_chk(`PFC_IDX_UNI_TIME, 32'hFFFF);
      rd_chk(`PFC_IDX_DA_LOW, 32'hC2000001);
      rd_chk(`PFC_IDX_DA_HIGH, 32'h0180);
      rd_chk(`PFC_IDX_SA_LOW, 32'hCBFC5ADD);
      rd_chk(`PFC_IDX_SA_HIGH, 32'hE100);
      chk_val("dest addr", 48'h0180C2000001, pfc_dest_addr);
      chk_val("src addr", 48'hE100CBFC5ADD, pfc_src_addr);
   endtask
   task automatic t_addresses;
      logic [47:0] da [0:2];
      da = '{48'hFFFFFFFFFFFF, 48'h0123456789AB, 48'h0180C2000001};
      for (int i = 0; i < 3; i++) begin
         axi_wr(`PFC_IDX_DA_LOW, da[i][31:0], 2'h0);
         axi_wr(`PFC_IDX_DA_HIGH, {16'hA5A5, da[i][47:32]}, 2'h0);
         axi_wr(`PFC_IDX_SA_LOW, ~da[i][31:0], 2'h0);
         axi_wr(`PFC_IDX_SA_HIGH, {16'h5A5A, ~da[i][47:32]}, 2'h0);
         rd_chk(`PFC_IDX_DA_HIGH, {16'h0, da[i][47:32]});
         chk_val("dest addr", da[i], pfc_dest_addr);
         chk_val("src addr", ~da[i], pfc_src_addr);
         i_pfc_link_partner.send_xoff(0);
         @(posedge aclk);
         chk_val("frame dest", da[i], frame_da);
         chk_val("frame src", ~da[i], frame_sa);
      end
   endtask
   task automatic t_uniform;
      holdoff_run(3, 8'h08, 0);
      axi_wr(`PFC_IDX_UNI_EN, 32'h1, 2'h0);
      for (int t = 1; t < 8; t += 6) begin
         axi_wr(`PFC_IDX_UNI_TIME, t, 2'h0);
         holdoff_run(3, 8'h08, t);
      end
      holdoff_run(6, 8'h00, 7);
   endtask
   task automatic t_queue_max;
      axi_wr(`PFC_IDX_QUEUE_SELECT, 32'h2, 2'h0);
      axi_wr(`PFC_IDX_HOLDOFF_TIME_Q, 32'h9, 2'h0);
      axi_wr(`PFC_IDX_PAUSE_TIME_Q, 32'h1234, 2'h0);
      axi_wr(`PFC_IDX_CTRL, 32'h4, 2'h0);
      axi_wr(`PFC_IDX_UNI_TIME, 32'h4, 2'h0);
      chk_val("pause table q2", 48'h1234, {32'h0, pause_time_table[47:32]});
      chk_val("pause table q1", 48'hFFFF, {32'h0, pause_time_table[31:16]});
      holdoff_run(2, 8'h04, 9);
      holdoff_run(2, 8'h00, 4);
      axi_wr(`PFC_IDX_UNI_EN, 32'h0, 2'h0);
      holdoff_run(2, 8'h00, 0);
      holdoff_run(2, 8'h04, 9);
      t_req_drop;
      axi_wr(`PFC_IDX_UNI_EN, 32'h1, 2'h0);
      axi_wr(`PFC_IDX_UNI_TIME, 32'hC, 2'h0);
      holdoff_run(2, 8'h04, 12);
      axi_wr(`PFC_IDX_QUEUE_SELECT, 32'h5, 2'h0);
      rd_chk(`PFC_IDX_QUEUE_SELECT, 32'h5);
      rd_chk(`PFC_IDX_HOLDOFF_TIME_Q, 32'hFFFF);
   endtask
   // request dropped three cycles after the xoff cuts the per-queue hold-off short
   task automatic t_req_drop;
      logic [47:0] n;
      n = '0;
      i_pfc_link_partner.set_req(8'h04);
      @(posedge aclk);
      i_pfc_link_partner.send_xoff(2);
      for (int k = 0; k < 40; k++) begin
         @(negedge aclk);
         n = n + holdoff_active[2];
         @(posedge aclk);
         if (k == 2) i_pfc_link_partner.set_req(8'h00);
      end
      chk_val("holdoff q2 dropped", 48'h4, n);
   endtask
   task automatic t_bus_errors;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(12'h613, 32'h1, 2'h2);
      axi_rd(12'h700, d, r);
      chk_resp("rresp unmapped", 2'h2, r);
      chk_val("rdata unmapped", 48'h0, {16'h0, d});
   endtask
   // ------------------------------
   // run control
   // ------------------------------
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_values;
      t_addresses;
      t_uniform;
      t_queue_max;
      t_bus_errors;
      stop_test;
   end
   // the whole sequence needs about five hundred and fifty cycles
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test;
   end
endmodule // pfc_tx_pause_config_test
`default_nettype wire
